// >>> logic/msc_pkg.sv
// Package for the machine state control block: field positions, reset, modes and opcodes
package msc_pkg;

  // ==========================================================================
  // Register geometry (bit 0 is the most significant bit, big-endian numbering)
  // ==========================================================================
  localparam int          MSC_WIDTH      = 32;
  localparam logic [31:0] MSC_RESET_VAL  = 32'h0000_0000;

  // Convert a big-endian bit number into a vector index
  localparam int POS_COPROC_AVAIL   = 31 - 6;
  localparam int POS_COPROC_FAULT   = 31 - 12;
  localparam int POS_WAIT           = 31 - 13;
  localparam int POS_CRIT_ENABLE    = 31 - 14;
  localparam int POS_EXT_IRQ_ENABLE = 31 - 16;
  localparam int POS_USER_MODE      = 31 - 17;
  localparam int POS_FLOAT_ALLOWED  = 31 - 18;
  localparam int POS_MCHK_ENABLE    = 31 - 19;
  localparam int POS_FLOAT_MODE_LO  = 31 - 20;
  localparam int POS_DEBUG_STALL    = 31 - 21;
  localparam int POS_DEBUG_IRQ      = 31 - 22;
  localparam int POS_FLOAT_MODE_HI  = 31 - 23;
  localparam int POS_INSTR_XLATE    = 31 - 26;
  localparam int POS_DATA_XLATE     = 31 - 27;

  // Implemented bits; all others are reserved and read as zero
  localparam logic [31:0] MSC_IMPL_MASK  = 32'h020E_FF30;

  // Bits forced by the interrupt entry: auxiliary exceptions, wait, external, user, float, float modes,
  // debug stall, translation cleared; critical, machine check, debug cleared by class
  localparam logic [31:0] MSC_ENTRY_KEEP = 32'h0200_0000;

  // ==========================================================================
  // Floating-point exception modes
  // ==========================================================================
  localparam logic [1:0] FMODE_IGNORE      = 2'h0;
  localparam logic [1:0] FMODE_IMP_RECOVER = 2'h1;
  localparam logic [1:0] FMODE_IMP_NONREC  = 2'h2;
  localparam logic [1:0] FMODE_PRECISE     = 2'h3;

  // ==========================================================================
  // Operation codes on the core's execution port
  // ==========================================================================
  localparam logic [2:0] OP_NONE       = 3'h0;
  localparam logic [2:0] OP_WRITE      = 3'h1;
  localparam logic [2:0] OP_READ       = 3'h2;
  localparam logic [2:0] OP_EXT_REG    = 3'h3;
  localparam logic [2:0] OP_EXT_IMM    = 3'h4;
  localparam logic [2:0] OP_DEV_WRITE  = 3'h5;
  localparam logic [2:0] OP_DEV_READ   = 3'h6;

  // Interrupt classes
  localparam logic [1:0] CLS_BASE      = 2'h0;
  localparam logic [1:0] CLS_CRITICAL  = 2'h1;
  localparam logic [1:0] CLS_MCHECK    = 2'h2;
  localparam logic [1:0] CLS_DEBUG     = 2'h3;

  // Alignment and data size codes
  localparam logic [1:0] SIZE_BYTE     = 2'h0;
  localparam logic [1:0] SIZE_HALF     = 2'h1;
  localparam logic [1:0] SIZE_WORD     = 2'h2;
  localparam logic [1:0] SIZE_STRING   = 2'h3;
  localparam int         STRING_MAX    = 128;
  localparam int         DEV_ADDR_W    = 10;

endpackage : msc_pkg

// >>> logic/msc_machine_state.sv
// Machine state register with interrupt save/restore, gating and access checks
//
// Contract
// RULE_01 - Write instruction loads whole register; read instruction returns it.
// RULE_02 - Register or immediate instruction changes only the external interrupt enable.
// RULE_03 - Interrupt entry saves and alters register; return restores saved copy.
// RULE_04 - Bit 6 marks the auxiliary unit available.
// RULE_05 - Bit 12 enables auxiliary unit exceptions.
// RULE_06 - Bit 13 holds wait until interrupt, reset or debug clear.
// RULE_07 - Bit 14 gates critical input and first watchdog time-out.
// RULE_08 - Bit 16 gates external input and both interval timers.
// RULE_09 - Bit 17 selects supervisor (0) or problem (1) state.
// RULE_10 - Bit 18 permits floating-point instructions.
// RULE_11 - Bit 19 enables machine check interrupts.
// RULE_12 - Bits 20 and 23 select the floating-point exception mode.
// RULE_13 - Bit 21 enables debug wait mode.
// RULE_14 - Bit 22 enables debug interrupts.
// RULE_15 - Bit 26 turns instruction translation on.
// RULE_16 - Bit 27 turns data translation on.
// RULE_17 - Reserved bits have no effect and read as zero.
// RULE_18 - Separate device control space reached only by two move instructions.
// RULE_19 - Data types are byte, halfword, word and 1 to 128 byte strings.
// RULE_20 - Bit 0 is the most significant bit of any value.
// RULE_21 - A multi-byte object's address is its lowest byte address.
// RULE_22 - Instructions are one word, word aligned.
`timescale 1ns/1ns

module msc_machine_state
  import msc_pkg::*;
(
  // Clock and reset
  input  wire logic                  CLOCK,
  input  wire logic                  RSTN,
  // Execution port
  input  wire logic [2:0]            OP_CODE,
  input  wire logic [31:0]           OP_SOURCE,
  input  wire logic                  OP_IMM_BIT,
  input  wire logic [DEV_ADDR_W-1:0] OP_DEV_ADDR,
  output logic      [31:0]           READ_DATA,
  output logic                       READ_VALID,
  output logic                       PRIV_FAULT,
  // Interrupt mechanism
  input  wire logic                  IRQ_TAKE,
  input  wire logic [1:0]            IRQ_CLASS,
  input  wire logic                  IRQ_RETURN,
  input  wire logic                  DEBUG_CLEAR_WAIT,
  // Interrupt requests (pins, synchronised here)
  input  wire logic                  CRIT_IRQ_IN,
  input  wire logic                  WATCHDOG_FIRST_IN,
  input  wire logic                  EXT_IRQ_IN,
  input  wire logic                  PERIODIC_TIMER_IN,
  input  wire logic                  FIXED_TIMER_IN,
  input  wire logic                  MCHECK_IN,
  input  wire logic                  DEBUG_EVENT_IN,
  input  wire logic                  COPROC_FAULT_IN,
  // Fetch and data access checks
  input  wire logic [31:0]           FETCH_ADDR,
  input  wire logic [31:0]           DATA_ADDR,
  input  wire logic [1:0]            DATA_SIZE,
  input  wire logic [7:0]            STRING_LEN,
  input  wire logic                  FLOAT_ISSUE,
  input  wire logic                  COPROC_ISSUE,
  // Machine state outputs
  output logic      [31:0]           MACHINE_STATE,
  output logic      [31:0]           SAVED_STATE,
  output logic                       WAIT_STATE,
  output logic                       USER_MODE_STATE,
  output logic      [1:0]            FLOAT_MODE,
  output logic                       INSTRUCTION_TRANSLATE_ON,
  output logic                       DATA_TRANSLATE_ON,
  output logic                       DEBUG_STALL_ENABLE,
  // Gated requests
  output logic                       CRIT_IRQ_REQ,
  output logic                       EXT_IRQ_REQ,
  output logic                       MCHECK_REQ,
  output logic                       DEBUG_IRQ_REQ,
  output logic                       COPROC_FAULT_REQ,
  output logic                       FLOAT_BLOCKED,
  output logic                       COPROC_BLOCKED,
  output logic                       FETCH_MISALIGNED,
  output logic                       DATA_MISALIGNED,
  output logic                       STRING_BAD_LEN,
  // Device control space port
  output logic                       DEV_STROBE,
  output logic                       DEV_WRITE,
  output logic      [DEV_ADDR_W-1:0] DEV_ADDR,
  output logic      [31:0]           DEV_WDATA,
  input  wire logic [31:0]           DEV_RDATA
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Reserved positions always read back as zero
  function automatic logic [31:0] clean(input logic [31:0] v);
    clean = v & MSC_IMPL_MASK; // RULE_17
  endfunction

  // Lowest byte address must be a multiple of the object size
  function automatic logic misaligned(input logic [31:0] a, input logic [1:0] sz);
    case (sz)
      SIZE_HALF: misaligned = a[0];
      SIZE_WORD: misaligned = |a[1:0];
      default:   misaligned = 1'b0;
    endcase
  endfunction

  // State seen by a handler: availability kept, higher-class enables kept by class
  function automatic logic [31:0] entry_value(input logic [31:0] v, input logic [1:0] cls);
    entry_value = v & MSC_ENTRY_KEEP; // RULE_03
    case (cls)
      CLS_BASE: begin
        entry_value[POS_CRIT_ENABLE] = v[POS_CRIT_ENABLE];
        entry_value[POS_MCHK_ENABLE] = v[POS_MCHK_ENABLE];
        entry_value[POS_DEBUG_IRQ]   = v[POS_DEBUG_IRQ];
      end
      CLS_CRITICAL: begin
        entry_value[POS_MCHK_ENABLE] = v[POS_MCHK_ENABLE];
      end
      default: entry_value = v & MSC_ENTRY_KEEP;
    endcase
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Two stages so a pin that changes near the edge cannot upset the gates
  logic [7:0] pin_meta_q;
  logic [7:0] pin_sync_q;
  logic [7:0] pins;

  assign pins = {COPROC_FAULT_IN, DEBUG_EVENT_IN, MCHECK_IN, FIXED_TIMER_IN,
                 PERIODIC_TIMER_IN, EXT_IRQ_IN, WATCHDOG_FIRST_IN, CRIT_IRQ_IN};

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= pins;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ==========================================================================
  // Machine state register and saved copy
  // ==========================================================================
  logic [31:0] state_q;
  logic [31:0] state_d;
  logic [31:0] saved_q;
  logic        user_mode;
  logic        priv_op;
  logic        op_accept;
  logic        dev_op;

  assign user_mode = state_q[POS_USER_MODE]; // RULE_20
  // Reads and writes of the state and device space are refused in problem state
  assign priv_op   = (OP_CODE == OP_WRITE) || (OP_CODE == OP_EXT_REG) || (OP_CODE == OP_EXT_IMM)
                     || (OP_CODE == OP_READ) || (OP_CODE == OP_DEV_WRITE) || (OP_CODE == OP_DEV_READ);
  // Moves are carried out only in supervisor state and never beside an interrupt event
  assign op_accept = !user_mode && !IRQ_TAKE && !IRQ_RETURN; // RULE_09
  assign dev_op    = (OP_CODE == OP_DEV_WRITE) || (OP_CODE == OP_DEV_READ); // RULE_18

  always_comb begin
    state_d = state_q;
    if (IRQ_TAKE) begin
      state_d = entry_value(state_q, IRQ_CLASS); // RULE_03
    end else if (IRQ_RETURN) begin
      state_d = saved_q; // RULE_03
    end else if (!user_mode) begin // RULE_09
      case (OP_CODE)
        OP_WRITE:   state_d = clean(OP_SOURCE); // RULE_01
        OP_EXT_REG: state_d[POS_EXT_IRQ_ENABLE] = OP_SOURCE[POS_EXT_IRQ_ENABLE]; // RULE_02
        OP_EXT_IMM: state_d[POS_EXT_IRQ_ENABLE] = OP_IMM_BIT; // RULE_02
        default:    state_d = state_q;
      endcase
    end
    if (DEBUG_CLEAR_WAIT) begin
      state_d[POS_WAIT] = 1'b0; // RULE_06
    end
  end

  // Reserved positions are dropped again on the way in, whatever the source
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= MSC_RESET_VAL; // RULE_06
    end else begin
      state_q <= clean(state_d); // RULE_17
    end
  end

  // One level of save only: a nested entry overwrites the copy
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      saved_q <= MSC_RESET_VAL;
    end else if (IRQ_TAKE) begin
      saved_q <= state_q; // RULE_03
    end
  end

  // ==========================================================================
  // Read port and privilege fault
  // ==========================================================================
  // Read data stands until the next read
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      READ_DATA  <= 32'h0000_0000;
      READ_VALID <= 1'b0;
    end else begin
      READ_VALID <= 1'b0;
      if (op_accept) begin
        if (OP_CODE == OP_READ) begin
          READ_DATA  <= clean(state_q); // RULE_01
          READ_VALID <= 1'b1;
        end else if (OP_CODE == OP_DEV_READ) begin
          READ_DATA  <= DEV_RDATA; // RULE_18
          READ_VALID <= 1'b1;
        end
      end
    end
  end

  // Refusal is flagged for one cycle; the state itself is left alone
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      PRIV_FAULT <= 1'b0;
    end else begin
      PRIV_FAULT <= priv_op && user_mode && !IRQ_TAKE && !IRQ_RETURN; // RULE_09
    end
  end

  // ==========================================================================
  // Device control space
  // ==========================================================================
  // Strobe and direction last one cycle
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      DEV_STROBE <= 1'b0;
      DEV_WRITE  <= 1'b0;
    end else begin
      DEV_STROBE <= op_accept && dev_op; // RULE_18
      DEV_WRITE  <= op_accept && (OP_CODE == OP_DEV_WRITE);
    end
  end

  // Address and data hold their last values between strobes
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      DEV_ADDR  <= '0;
      DEV_WDATA <= 32'h0000_0000;
    end else if (op_accept && dev_op) begin
      DEV_ADDR  <= OP_DEV_ADDR;
      DEV_WDATA <= OP_SOURCE;
    end
  end

  // ==========================================================================
  // Field outputs and gated requests
  // ==========================================================================
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      MACHINE_STATE <= MSC_RESET_VAL;
      SAVED_STATE   <= MSC_RESET_VAL;
    end else begin
      MACHINE_STATE <= clean(state_d); // RULE_17
      SAVED_STATE   <= IRQ_TAKE ? state_q : saved_q; // RULE_03
    end
  end

  // Field mirrors follow the next state, so they change on the same edge as the register
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      WAIT_STATE               <= 1'b0;
      USER_MODE_STATE          <= 1'b0;
      FLOAT_MODE               <= FMODE_IGNORE;
      INSTRUCTION_TRANSLATE_ON <= 1'b0;
      DATA_TRANSLATE_ON        <= 1'b0;
      DEBUG_STALL_ENABLE       <= 1'b0;
    end else begin
      WAIT_STATE               <= state_d[POS_WAIT]; // RULE_06
      USER_MODE_STATE          <= state_d[POS_USER_MODE]; // RULE_09
      FLOAT_MODE               <= {state_d[POS_FLOAT_MODE_HI], state_d[POS_FLOAT_MODE_LO]}; // RULE_12
      INSTRUCTION_TRANSLATE_ON <= state_d[POS_INSTR_XLATE]; // RULE_15
      DATA_TRANSLATE_ON        <= state_d[POS_DATA_XLATE]; // RULE_16
      DEBUG_STALL_ENABLE       <= state_d[POS_DEBUG_STALL]; // RULE_13
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      CRIT_IRQ_REQ     <= 1'b0;
      EXT_IRQ_REQ      <= 1'b0;
      MCHECK_REQ       <= 1'b0;
      DEBUG_IRQ_REQ    <= 1'b0;
      COPROC_FAULT_REQ <= 1'b0;
    end else begin
      CRIT_IRQ_REQ     <= state_q[POS_CRIT_ENABLE] && (pin_sync_q[0] || pin_sync_q[1]); // RULE_07
      EXT_IRQ_REQ      <= state_q[POS_EXT_IRQ_ENABLE] && (|pin_sync_q[4:2]); // RULE_08
      MCHECK_REQ       <= state_q[POS_MCHK_ENABLE] && pin_sync_q[5]; // RULE_11
      DEBUG_IRQ_REQ    <= state_q[POS_DEBUG_IRQ] && pin_sync_q[6]; // RULE_14
      COPROC_FAULT_REQ <= state_q[POS_COPROC_FAULT] && pin_sync_q[7]; // RULE_05
    end
  end

  // Gates use the settled state, so a block trails an enable change by one cycle
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      FLOAT_BLOCKED  <= 1'b0;
      COPROC_BLOCKED <= 1'b0;
    end else begin
      FLOAT_BLOCKED  <= FLOAT_ISSUE && !state_q[POS_FLOAT_ALLOWED]; // RULE_10
      COPROC_BLOCKED <= COPROC_ISSUE && !state_q[POS_COPROC_AVAIL]; // RULE_04
    end
  end

  // ==========================================================================
  // Alignment and data type checks
  // ==========================================================================
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      FETCH_MISALIGNED <= 1'b0;
    end else begin
      FETCH_MISALIGNED <= misaligned(FETCH_ADDR, SIZE_WORD); // RULE_22
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      DATA_MISALIGNED <= 1'b0;
    end else begin
      DATA_MISALIGNED <= misaligned(DATA_ADDR, DATA_SIZE); // RULE_21
    end
  end

  // A string is one to STRING_MAX bytes; a zero length is refused as well
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      STRING_BAD_LEN <= 1'b0;
    end else begin
      STRING_BAD_LEN <= (DATA_SIZE == SIZE_STRING) &&
                        ((STRING_LEN == 8'h00) || (32'(STRING_LEN) > STRING_MAX)); // RULE_19
    end
  end

endmodule // msc_machine_state

// >>> sim/msc_machine_state_assertions.sv
// Concurrent checks on the machine state block ports
`timescale 1ns/1ns
module msc_chk
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RSTN,
  // Requests
  input wire logic [2:0]  OP_CODE,
  input wire logic [31:0] OP_SOURCE,
  input wire logic        OP_IMM_BIT,
  input wire logic        IRQ_TAKE,
  input wire logic        IRQ_RETURN,
  input wire logic        DEBUG_CLEAR_WAIT,
  // Answers
  input wire logic [31:0] MACHINE_STATE,
  input wire logic [31:0] SAVED_STATE,
  input wire logic [31:0] READ_DATA,
  input wire logic        READ_VALID,
  input wire logic        PRIV_FAULT,
  input wire logic [1:0]  FLOAT_MODE,
  input wire logic        WAIT_STATE,
  input wire logic        EXT_IRQ_REQ
);
  // ====================
  // Helpers
  localparam logic [31:0] IMPL = 32'h020E_FF30;
  localparam logic [31:0] EXT  = 32'h0000_8000;
  logic quiet;
  logic go;
  assign quiet = !IRQ_TAKE && !IRQ_RETURN && !DEBUG_CLEAR_WAIT;
  assign go    = quiet && !MACHINE_STATE[POS_USER_MODE];
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // ====================
  // Properties
  whole_write_a: assert property (go && OP_CODE == OP_WRITE |=> MACHINE_STATE == ($past(OP_SOURCE) & IMPL))
    else $error("state write mismatch");
  read_back_a: assert property (go && OP_CODE == OP_READ |=>
    READ_VALID && READ_DATA == $past(MACHINE_STATE))
    else $error("state read mismatch");
  ext_only_a: assert property (go && OP_CODE == OP_EXT_IMM |=>
    MACHINE_STATE == (($past(MACHINE_STATE) & ~EXT) | ($past(OP_IMM_BIT) ? EXT : 32'h0)))
    else $error("external enable update mismatch");
  entry_save_a: assert property (IRQ_TAKE |=> SAVED_STATE == $past(MACHINE_STATE))
    else $error("saved copy mismatch");
  return_restore_a: assert property (IRQ_RETURN && !IRQ_TAKE && !DEBUG_CLEAR_WAIT |=>
    MACHINE_STATE == $past(SAVED_STATE))
    else $error("restore mismatch");
  reserved_zero_a: assert property ((MACHINE_STATE & ~IMPL) == 32'h0)
    else $error("reserved bit set");
  user_refused_a: assert property (OP_CODE != OP_NONE && quiet && MACHINE_STATE[POS_USER_MODE] |=>
    PRIV_FAULT && $stable(MACHINE_STATE))
    else $error("problem state op not refused");
  float_mode_a: assert property (
    FLOAT_MODE == {MACHINE_STATE[POS_FLOAT_MODE_HI], MACHINE_STATE[POS_FLOAT_MODE_LO]})
    else $error("float mode mismatch");
  wait_clear_a: assert property (DEBUG_CLEAR_WAIT |=> !WAIT_STATE && !MACHINE_STATE[POS_WAIT])
    else $error("wait not cleared");
  ext_gate_a: assert property (EXT_IRQ_REQ |-> $past(MACHINE_STATE[POS_EXT_IRQ_ENABLE]))
    else $error("external request not gated");
endmodule // msc_chk

bind msc_machine_state msc_chk i_chk (.CLOCK, .RSTN, .OP_CODE, .OP_SOURCE, .OP_IMM_BIT, .IRQ_TAKE, .IRQ_RETURN,
  .DEBUG_CLEAR_WAIT, .MACHINE_STATE, .SAVED_STATE, .READ_DATA, .READ_VALID, .PRIV_FAULT, .FLOAT_MODE,
  .WAIT_STATE, .EXT_IRQ_REQ);

// >>> sim/msc_testbench.sv
// Self-checking bench for the machine state block
`timescale 1ns/1ns
module testbench;
  import msc_pkg::*;
  // ====================
  // Signals
  typedef struct packed {logic [2:0] op; logic [31:0] src; logic imm; logic [31:0] st;} msc_row_t;
  typedef struct packed {logic [31:0] fa; logic [31:0] da; logic [1:0] sz; logic [7:0] len; logic [2:0] ex;} msc_al_t;
  localparam logic [31:0] ALL = 32'h020E_BF30;
  logic        clk = 1'b0, rst_n = 1'b0, op_imm = 1'b0, irq_take = 1'b0, irq_ret = 1'b0, dbg_clr = 1'b0;
  logic        fl_issue = 1'b0, cp_issue = 1'b0, rd_valid, priv, wait_st, user_st, itr, dtr, dstall;
  logic        fl_blk, cp_blk, f_mis, d_mis, s_bad, dv_stb, dv_wr;
  logic [1:0]  irq_class = 2'h0, data_size = 2'h0, fmode;
  logic [2:0]  op_code = 3'h0;
  logic [4:0]  reqs;
  logic [7:0]  pins = 8'h00, str_len = 8'h01;
  logic [9:0]  dev_addr = 10'h2C3, dv_addr;
  logic [31:0] op_src = 32'h0, fetch_addr = 32'h0, data_addr = 32'h0, dev_rdata = 32'h1357_9BDF;
  logic [31:0] rd_data, state, saved, dv_wdata;
  int          err_total = 0, n_checks = 0;
  msc_row_t rows [9] = '{'{OP_WRITE, 32'hFFFF_BFFF, 1'b0, ALL}, '{OP_EXT_IMM, 32'h0, 1'b0, ALL & 32'hFFFF_7FFF},
    '{OP_EXT_REG, 32'hFFFF_FFFF, 1'b0, ALL}, '{OP_WRITE, 32'hFDF1_00CF, 1'b0, 32'h0},
    '{OP_EXT_IMM, 32'h0, 1'b1, 32'h0000_8000}, '{OP_WRITE, 32'h0000_0800, 1'b0, 32'h0000_0800},
    '{OP_WRITE, 32'h0000_0100, 1'b0, 32'h0000_0100}, '{OP_WRITE, 32'h0000_0900, 1'b0, 32'h0000_0900},
    '{OP_WRITE, 32'h0000_0030, 1'b0, 32'h0000_0030}};
  logic [31:0] keep [4] = '{32'h0202_1200, 32'h0200_1000, 32'h0200_0000, 32'h0200_0000};
  msc_al_t als [6] = '{'{32'h2, 32'h1, SIZE_HALF, 8'h0, 3'h6}, '{32'h4, 32'h2, SIZE_HALF, 8'h0, 3'h0},
    '{32'h0, 32'h2, SIZE_WORD, 8'h0, 3'h2}, '{32'h0, 32'h0, SIZE_STRING, 8'h0, 3'h1},
    '{32'h0, 32'h3, SIZE_STRING, 8'h80, 3'h0}, '{32'h0, 32'h0, SIZE_STRING, 8'h81, 3'h1}};

  always #25 clk = ~clk;

  msc_machine_state i_dut (.CLOCK(clk), .RSTN(rst_n), .OP_CODE(op_code), .OP_SOURCE(op_src), .OP_IMM_BIT(op_imm),
    .OP_DEV_ADDR(dev_addr), .READ_DATA(rd_data), .READ_VALID(rd_valid), .PRIV_FAULT(priv), .IRQ_TAKE(irq_take),
    .IRQ_CLASS(irq_class), .IRQ_RETURN(irq_ret), .DEBUG_CLEAR_WAIT(dbg_clr), .CRIT_IRQ_IN(pins[0]),
    .WATCHDOG_FIRST_IN(pins[1]), .EXT_IRQ_IN(pins[2]), .PERIODIC_TIMER_IN(pins[3]), .FIXED_TIMER_IN(pins[4]),
    .MCHECK_IN(pins[5]), .DEBUG_EVENT_IN(pins[6]), .COPROC_FAULT_IN(pins[7]), .FETCH_ADDR(fetch_addr),
    .DATA_ADDR(data_addr), .DATA_SIZE(data_size), .STRING_LEN(str_len), .FLOAT_ISSUE(fl_issue),
    .COPROC_ISSUE(cp_issue), .MACHINE_STATE(state), .SAVED_STATE(saved), .WAIT_STATE(wait_st),
    .USER_MODE_STATE(user_st), .FLOAT_MODE(fmode), .INSTRUCTION_TRANSLATE_ON(itr), .DATA_TRANSLATE_ON(dtr),
    .DEBUG_STALL_ENABLE(dstall), .CRIT_IRQ_REQ(reqs[4]), .EXT_IRQ_REQ(reqs[3]), .MCHECK_REQ(reqs[2]),
    .DEBUG_IRQ_REQ(reqs[1]), .COPROC_FAULT_REQ(reqs[0]), .FLOAT_BLOCKED(fl_blk), .COPROC_BLOCKED(cp_blk),
    .FETCH_MISALIGNED(f_mis), .DATA_MISALIGNED(d_mis), .STRING_BAD_LEN(s_bad), .DEV_STROBE(dv_stb),
    .DEV_WRITE(dv_wr), .DEV_ADDR(dv_addr), .DEV_WDATA(dv_wdata), .DEV_RDATA(dev_rdata));

  // ====================
  // Tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input logic [2:0] op, input logic [31:0] src, input logic imm, input logic [2:0] ctl,
                      input logic [1:0] cls);
    @(posedge clk);
    op_code <= op;
    op_src <= src;
    op_imm <= imm;
    {irq_take, irq_ret, dbg_clr} <= ctl;
    irq_class <= cls;
    @(posedge clk);
    op_code <= OP_NONE;
    {irq_take, irq_ret, dbg_clr} <= 3'h0;
    #1;
  endtask

  task automatic give_verdict();
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ====================
  // Sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check("reset state", state, 32'h0);
    foreach (rows[i]) begin
      step(rows[i].op, rows[i].src, rows[i].imm, 3'h0, 2'h0);
      check("state", state, rows[i].st);
      check("fields", 32'({fmode, itr, dtr, dstall, wait_st, user_st}), 32'({rows[i].st[POS_FLOAT_MODE_HI],
        rows[i].st[POS_FLOAT_MODE_LO], rows[i].st[POS_INSTR_XLATE], rows[i].st[POS_DATA_XLATE],
        rows[i].st[POS_DEBUG_STALL], rows[i].st[POS_WAIT], rows[i].st[POS_USER_MODE]}));
      step(OP_READ, 32'h0, 1'b0, 3'h0, 2'h0);
      check("read", rd_data, rows[i].st);
      check("read valid", 32'(rd_valid), 32'h1);
    end
    foreach (keep[c]) begin
      step(OP_WRITE, ALL, 1'b0, 3'h0, 2'h0);
      step(OP_NONE, 32'h0, 1'b0, 3'h4, c[1:0]);
      check("saved", saved, ALL);
      check("entry", state, keep[c]);
      step(OP_NONE, 32'h0, 1'b0, 3'h2, 2'h0);
      check("return", state, ALL);
    end
    @(posedge clk);
    pins <= 8'hFF;
    fl_issue <= 1'b1;
    cp_issue <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("gates on", 32'({reqs, fl_blk, cp_blk}), 32'h7C);
    step(OP_WRITE, 32'h0, 1'b0, 3'h0, 2'h0);
    @(posedge clk);
    #1;
    check("gates off", 32'({reqs, fl_blk, cp_blk}), 32'h03);
    step(OP_WRITE, 32'h0004_0000, 1'b0, 3'h0, 2'h0);
    step(OP_NONE, 32'h0, 1'b0, 3'h1, 2'h0);
    check("debug clear", state, 32'h0);
    check("wait flag", 32'(wait_st), 32'h0);
    step(OP_DEV_WRITE, 32'hA5A5_5A5A, 1'b0, 3'h0, 2'h0);
    check("dev wdata", dv_wdata, 32'hA5A5_5A5A);
    check("dev write", 32'({dv_stb, dv_wr, dv_addr}), 32'h0EC3);
    step(OP_DEV_READ, 32'h0, 1'b0, 3'h0, 2'h0);
    check("dev read", rd_data, 32'h1357_9BDF);
    check("dev strobe", 32'({dv_stb, dv_wr}), 32'h2);
    step(OP_WRITE, 32'h0000_4000, 1'b0, 3'h0, 2'h0);
    step(OP_WRITE, ALL, 1'b0, 3'h0, 2'h0);
    check("refused", 32'({priv, state[30:0]}), 32'h8000_4000);
    step(OP_NONE, 32'h0, 1'b0, 3'h4, CLS_BASE);
    check("leave user", state, 32'h0);
    foreach (als[i]) begin
      @(posedge clk);
      fetch_addr <= als[i].fa;
      data_addr <= als[i].da;
      data_size <= als[i].sz;
      str_len <= als[i].len;
      @(posedge clk);
      #1;
      check("alignment", 32'({f_mis, d_mis, s_bad}), 32'(als[i].ex));
    end
    give_verdict();
  end

  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule // testbench
